// ===== rtl/pair_trig_pkg.sv
// constants for the per-pair conversion trigger control block
// assumes a 32-bit apb master and trigger sources on the same pclk
// ****************************************************************
// How it works
// - two slots per register, upper byte higher slot
// - selectors at bits 12:8 and 4:0
// - slot n converts inputs 2n and 2n+1
// - codes 11111 timer2, 01100 timer1 period match
// - codes 11110..10111 current-limit of generators 8..1
// - codes 10110..01110 secondary of generators 9..1
// - code 01101 reserved, selects no trigger
// - codes 01011..00100 primary of generators 8..1
// - code 00011 pwm special event trigger
// - code 00010 shared global software trigger
// - code 00001 own software bit only
// - code 00000 disables, never sets pending
// - pending sets on trigger, clears on completion
// - software bit starts conversion, clears as pending sets
// - triggers while busy stay pending; on the granted slot they merge unless in its completion cycle
// - irq enable gates completion interrupt request
// ****************************************************************
package pair_trig_pkg;

  // ****************************************************************
  // bus and slot geometry
  // ****************************************************************
  localparam int APB_AW    = 8;
  localparam int APB_DW    = 32;
  localparam int NUM_REGS  = 3;
  localparam int NUM_SLOTS = 2 * NUM_REGS;
  localparam int PAIR_W    = 3;
  localparam int INPUT_W   = PAIR_W + 1;
  localparam int N_PRI     = 8;
  localparam int N_SEC     = 9;
  localparam int N_CL      = 8;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [APB_AW-1:0] ADDR_CTRL_0     = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_CTRL_1     = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_CTRL_2     = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_IRQ_CLEAR  = 8'h14;
  localparam logic [APB_AW-1:0] ADDR_IRQ_ENABLE = 8'h18;

  // ****************************************************************
  // slot byte layout and reset values
  // ****************************************************************
  localparam int SLOT_BYTE_W  = 8;
  localparam int IRQ_EN_BIT   = 7;
  localparam int PEND_BIT     = 6;
  localparam int SOFT_BIT     = 5;
  localparam int SEL_W        = 5;
  localparam logic [SEL_W-1:0]     SEL_RESET  = 5'h00;
  localparam logic [NUM_SLOTS-1:0] SLOTS_ZERO = 6'h00;

  // ****************************************************************
  // trigger selector codes
  // ****************************************************************
  localparam logic [SEL_W-1:0] SEL_OFF       = 5'h00;
  localparam logic [SEL_W-1:0] SEL_SOFT_OWN  = 5'h01;
  localparam logic [SEL_W-1:0] SEL_SOFT_GLOB = 5'h02;
  localparam logic [SEL_W-1:0] SEL_SPECIAL   = 5'h03;
  localparam logic [SEL_W-1:0] SEL_PRI_LO    = 5'h04;
  localparam logic [SEL_W-1:0] SEL_PRI_HI    = 5'h0b;
  localparam logic [SEL_W-1:0] SEL_TIMER1    = 5'h0c;
  localparam logic [SEL_W-1:0] SEL_RESERVED  = 5'h0d;
  localparam logic [SEL_W-1:0] SEL_SEC_LO    = 5'h0e;
  localparam logic [SEL_W-1:0] SEL_SEC_HI    = 5'h16;
  localparam logic [SEL_W-1:0] SEL_CL_LO     = 5'h17;
  localparam logic [SEL_W-1:0] SEL_CL_HI     = 5'h1e;
  localparam logic [SEL_W-1:0] SEL_TIMER2    = 5'h1f;

endpackage

// ===== rtl/pair_trigger_ctrl.sv
// per-pair conversion trigger slots with apb registers and grant logic
// assumes triggers and the conversion engine share pclk; conv_done is a
// one-cycle pulse from the engine ending the granted pair conversion
`timescale 1ns/10ps
module pair_trigger_ctrl (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [pair_trig_pkg::APB_AW-1:0]     paddr,
  input  wire logic [pair_trig_pkg::APB_DW-1:0]     pwdata,
  input  wire logic [3:0]                           pstrb,
  output logic      [pair_trig_pkg::APB_DW-1:0]     prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic [pair_trig_pkg::N_PRI-1:0]      pwm_primary_trig,
  input  wire logic [pair_trig_pkg::N_SEC-1:0]      pwm_secondary_trig,
  input  wire logic [pair_trig_pkg::N_CL-1:0]       pwm_curlim_trig,
  input  wire logic                                 pwm_special_trig,
  input  wire logic                                 timer1_period_match,
  input  wire logic                                 timer2_period_match,
  input  wire logic                                 global_soft_trig,
  input  wire logic                                 conv_done,
  output logic                                      conv_req,
  output logic      [pair_trig_pkg::PAIR_W-1:0]     conv_pair,
  output logic      [pair_trig_pkg::INPUT_W-1:0]    conv_even_input,
  output logic      [pair_trig_pkg::INPUT_W-1:0]    conv_odd_input,
  output logic                                      irq
);
  import pair_trig_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [SEL_W-1:0]     sel_q [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] irq_en_q;
  logic [NUM_SLOTS-1:0] soft_q;
  logic [NUM_SLOTS-1:0] pend_q;
  logic [NUM_SLOTS-1:0] trig_hit;
  logic [NUM_SLOTS-1:0] irq_status_q;
  logic [NUM_SLOTS-1:0] irq_enable_q;
  logic                 busy_q;
  logic [PAIR_W-1:0]    cur_q;
  logic [PAIR_W-1:0]    pick;
  logic                 any_pend;
  logic                 done_ev;
  logic [APB_DW-1:0]    prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic                 conv_req_q;
  logic [PAIR_W-1:0]    conv_pair_q;
  logic [INPUT_W-1:0]   conv_even_q;
  logic [INPUT_W-1:0]   conv_odd_q;
  logic                 irq_q;
  logic                 wr_acc;
  logic                 setup;
  logic                 addr_ok;
  logic [APB_DW-1:0]    rd_d;

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign conv_req        = conv_req_q;
  assign conv_pair       = conv_pair_q;
  assign conv_even_input = conv_even_q;
  assign conv_odd_input  = conv_odd_q;
  assign irq             = irq_q;

  // ****************************************************************
  // trigger source decode
  // ****************************************************************
  function automatic logic src_hit(
    input logic [SEL_W-1:0] code,
    input logic             own_soft,
    input logic [N_PRI-1:0] pri,
    input logic [N_SEC-1:0] sec,
    input logic [N_CL-1:0]  cl,
    input logic             special,
    input logic             t1,
    input logic             t2,
    input logic             glob
  );
    logic [SEL_W-1:0] idx;
    src_hit = 1'b0;
    idx     = SEL_OFF;
    if (code == SEL_TIMER2) begin
      src_hit = t2;
    end else if (code >= SEL_CL_LO) begin
      idx     = code - SEL_CL_LO;
      src_hit = cl[idx[2:0]];
    end else if (code >= SEL_SEC_LO) begin
      idx     = code - SEL_SEC_LO;
      src_hit = sec[idx[3:0]];
    end else if (code == SEL_RESERVED) begin
      src_hit = 1'b0;
    end else if (code == SEL_TIMER1) begin
      src_hit = t1;
    end else if (code >= SEL_PRI_LO) begin
      idx     = code - SEL_PRI_LO;
      src_hit = pri[idx[2:0]];
    end else if (code == SEL_SPECIAL) begin
      src_hit = special;
    end else if (code == SEL_SOFT_GLOB) begin
      src_hit = glob;
    end else if (code == SEL_SOFT_OWN) begin
      src_hit = own_soft;
    end else begin
      src_hit = 1'b0;
    end
  endfunction

  // triggers are same-clock pulses, so one cycle is enough to latch
  always_comb begin
    for (int s = 0; s < NUM_SLOTS; s++) begin
      trig_hit[s] = src_hit(sel_q[s], soft_q[s], pwm_primary_trig, pwm_secondary_trig,
                            pwm_curlim_trig, pwm_special_trig, timer1_period_match,
                            timer2_period_match, global_soft_trig);
    end
  end

  // ****************************************************************
  // apb slave: one wait-free access phase, answer registered in setup
  // ****************************************************************
  assign setup   = psel & ~penable & ~pready_q;
  assign wr_acc  = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign addr_ok = (paddr == ADDR_CTRL_0) | (paddr == ADDR_CTRL_1) |
                   (paddr == ADDR_CTRL_2) | (paddr == ADDR_IRQ_STATUS) |
                   (paddr == ADDR_IRQ_CLEAR) | (paddr == ADDR_IRQ_ENABLE);

  always_comb begin
    rd_d = '0;
    for (int r = 0; r < NUM_REGS; r++) begin
      if (paddr == ADDR_CTRL_0 + APB_AW'(4 * r)) begin
        // lower byte is slot 2r, upper byte slot 2r+1
        for (int h = 0; h < 2; h++) begin
          rd_d[h * SLOT_BYTE_W + IRQ_EN_BIT] = irq_en_q[2 * r + h];
          rd_d[h * SLOT_BYTE_W + PEND_BIT]   = pend_q[2 * r + h];
          rd_d[h * SLOT_BYTE_W + SOFT_BIT]   = soft_q[2 * r + h];
          rd_d[h * SLOT_BYTE_W +: SEL_W]     = sel_q[2 * r + h];
        end
      end
    end
    if (paddr == ADDR_IRQ_STATUS) begin
      rd_d[NUM_SLOTS-1:0] = irq_status_q;
    end
    if (paddr == ADDR_IRQ_ENABLE) begin
      rd_d[NUM_SLOTS-1:0] = irq_enable_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~addr_ok;
      if (setup && !pwrite) begin
        prdata_q <= rd_d;
      end else if (!psel) begin
        prdata_q <= '0;
      end
    end
  end

  // ****************************************************************
  // slot control bytes
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        sel_q[s] <= SEL_RESET;
      end
      irq_en_q <= SLOTS_ZERO;
      soft_q   <= SLOTS_ZERO;
    end else begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        // hardware clears the own bit as its pending flag sets
        if (trig_hit[s]) begin
          soft_q[s] <= 1'b0;
        end
        // a fresh write wins over the self-clear so no request is lost
        if (wr_acc && paddr == ADDR_CTRL_0 + APB_AW'(4 * (s / 2)) && pstrb[s % 2]) begin
          sel_q[s]    <= pwdata[(s % 2) * SLOT_BYTE_W +: SEL_W];
          soft_q[s]   <= pwdata[(s % 2) * SLOT_BYTE_W + SOFT_BIT];
          irq_en_q[s] <= pwdata[(s % 2) * SLOT_BYTE_W + IRQ_EN_BIT];
        end
      end
    end
  end

  // ****************************************************************
  // pending flags and grant
  // ****************************************************************
  assign done_ev = conv_done & busy_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= SLOTS_ZERO;
    end else begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        // set wins: a trigger in the completing cycle asks again
        if (trig_hit[s]) begin
          pend_q[s] <= 1'b1;
        end else if (done_ev && cur_q == PAIR_W'(s)) begin
          pend_q[s] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    pick     = '0;
    any_pend = |pend_q;
    for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
      if (pend_q[s]) begin
        pick = PAIR_W'(s);
      end
    end
  end

  // pending slots simply wait while the engine is busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q      <= 1'b0;
      cur_q       <= '0;
      conv_req_q  <= 1'b0;
      conv_pair_q <= '0;
      conv_even_q <= '0;
      conv_odd_q  <= '0;
    end else if (done_ev) begin
      busy_q     <= 1'b0;
      conv_req_q <= 1'b0;
    end else if (!busy_q && any_pend) begin
      busy_q      <= 1'b1;
      cur_q       <= pick;
      conv_req_q  <= 1'b1;
      conv_pair_q <= pick;
      conv_even_q <= {pick, 1'b0};
      conv_odd_q  <= {pick, 1'b1};
    end
  end

  // ****************************************************************
  // interrupts: sticky status, write-one clear, enable mask
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= SLOTS_ZERO;
      irq_enable_q <= SLOTS_ZERO;
      irq_q        <= 1'b0;
    end else begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        if (done_ev && cur_q == PAIR_W'(s) && irq_en_q[s]) begin
          irq_status_q[s] <= 1'b1;
        end else if (wr_acc && paddr == ADDR_IRQ_CLEAR && pstrb[0] && pwdata[s]) begin
          irq_status_q[s] <= 1'b0;
        end
      end
      if (wr_acc && paddr == ADDR_IRQ_ENABLE && pstrb[0]) begin
        irq_enable_q <= pwdata[NUM_SLOTS-1:0];
      end
      irq_q <= |(irq_status_q & irq_enable_q);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_ctrl0_lo;
  assign wr_ctrl0_lo = wr_acc && paddr == ADDR_CTRL_0 && pstrb[0];

  chk_off_no_pend: assert property (
    (sel_q[0] == SEL_OFF && !pend_q[0]) |=> !pend_q[0])
    else $error("disabled slot became pending");
  chk_trig_sets_pend: assert property (
    trig_hit[0] |=> pend_q[0])
    else $error("trigger pulse did not set pending");
  chk_done_clears: assert property (
    (done_ev && cur_q == '0 && !trig_hit[0]) |=> !pend_q[0])
    else $error("pending not cleared on completion");
  chk_soft_selfclear: assert property (
    (soft_q[0] && sel_q[0] == SEL_SOFT_OWN && !wr_ctrl0_lo) |=> (pend_q[0] && !soft_q[0]))
    else $error("software bit did not start and self-clear");
  chk_timer2_route: assert property (
    (sel_q[1] == SEL_TIMER2 && timer2_period_match && !pend_q[1]) |=> pend_q[1])
    else $error("timer2 match not routed");
  chk_lowest_grant: assert property (
    (!busy_q && pend_q[0]) |=> (busy_q && conv_pair_q == '0))
    else $error("lowest pending slot not granted");
  chk_pend_held: assert property (
    (pend_q[2] && !(done_ev && cur_q == 3'h2)) |=> pend_q[2])
    else $error("pending request dropped");
  chk_irq_gated: assert property (
    (done_ev && cur_q == '0 && !irq_en_q[0] && !irq_status_q[0]) |=> !irq_status_q[0])
    else $error("interrupt raised with enable low");
  chk_irq_raised: assert property (
    (done_ev && cur_q == '0 && irq_en_q[0] && irq_enable_q[0] &&
     !(wr_acc && paddr == ADDR_IRQ_ENABLE)) |=> ##1 irq_q)
    else $error("enabled completion gave no interrupt");
  chk_pair_inputs: assert property (
    conv_req_q |-> (conv_even_q == {conv_pair_q, 1'b0} && conv_odd_q == {conv_pair_q, 1'b1}))
    else $error("pair inputs mismatch");
  chk_req_steady: assert property (
    (conv_req_q && !done_ev) |=> (conv_req_q && $stable(conv_pair_q)))
    else $error("request dropped or moved before completion");
  chk_req_ends: assert property (
    done_ev |=> !conv_req_q)
    else $error("request still high after completion");
  chk_idle_quiet: assert property (
    (!busy_q && pend_q == SLOTS_ZERO) |=> !conv_req_q)
    else $error("request raised with nothing pending");

  // one source of each selector group except timer2 and off, checked on every slot
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_route_chk
    chk_t1_route: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_q[g] == SEL_TIMER1 && timer1_period_match) |=> pend_q[g])
      else $error("timer1 match not routed");
    chk_cl_route: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_q[g] == SEL_CL_LO && pwm_curlim_trig[0]) |=> pend_q[g])
      else $error("current-limit trigger not routed");
    chk_sec_route: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_q[g] == SEL_SEC_HI && pwm_secondary_trig[N_SEC-1]) |=> pend_q[g])
      else $error("secondary trigger not routed");
    chk_reserved_idle: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_q[g] == SEL_RESERVED && !pend_q[g]) |=> !pend_q[g])
      else $error("reserved code set pending");
    chk_pri_route: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_q[g] == SEL_PRI_HI && pwm_primary_trig[N_PRI-1]) |=> pend_q[g])
      else $error("primary trigger not routed");
    chk_special_route: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_q[g] == SEL_SPECIAL && pwm_special_trig) |=> pend_q[g])
      else $error("special event trigger not routed");
    chk_glob_route: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_q[g] == SEL_SOFT_GLOB && global_soft_trig) |=> pend_q[g])
      else $error("global software trigger not routed");
    chk_own_only: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_q[g] == SEL_SOFT_OWN && !soft_q[g] && !pend_q[g]) |=> !pend_q[g])
      else $error("own-bit slot pended without its bit");
  end

  cov_two_pending: cover property (pend_q[0] && pend_q[5] && busy_q);
  cov_soft_start:  cover property (soft_q[1] && sel_q[1] == SEL_SOFT_OWN ##1 pend_q[1]);
  cov_irq_fire:    cover property (done_ev ##[1:3] irq_q);
  cov_all_pending: cover property (&pend_q);
  cov_regrant:     cover property (done_ev ##2 conv_req_q);

endmodule

// ===== verification/conv_engine_model.sv
// stand-in for the conversion engine on the far side of the request port
// assumes conv_req holds from grant until the edge after conv_done
`timescale 1ns/10ps
module conv_engine_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       conv_req,
  input  wire logic [7:0] delay_cycles,
  output logic            conv_done
);
  // ****************************************************************
  // one completion pulse per request
  // ****************************************************************
  logic [7:0] cnt_q;
  logic       sent_q;

  // sent_q keeps a held request from being answered twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 8'h00;
      sent_q    <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (!conv_req) begin
        cnt_q  <= 8'h00;
        sent_q <= 1'b0;
      end else if (!sent_q && (cnt_q + 8'h01) >= delay_cycles) begin
        conv_done <= 1'b1;
        sent_q    <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule

// ===== verification/test_pair_trigger_ctrl.sv
// self-checking bench: apb master, trigger pulses and a routing model
// assumes the engine stand-in answers each request after eng_delay cycles
`timescale 1ns/10ps
module test_pair_trigger_ctrl;
  import pair_trig_pkg::*;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        conv_done, conv_req, irq, er, hit;
  logic [7:0]  paddr, eng_delay;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, conv_even_input, conv_odd_input;
  logic [28:0] trg;
  logic [2:0]  conv_pair;
  int          n_mismatch, checks_done, s, c, j;
  int          exp_q[$];

  pair_trigger_ctrl u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_primary_trig(trg[9:2]), .pwm_secondary_trig(trg[19:11]),
    .pwm_curlim_trig(trg[27:20]), .pwm_special_trig(trg[1]), .timer1_period_match(trg[10]),
    .timer2_period_match(trg[28]), .global_soft_trig(trg[0]), .conv_done(conv_done),
    .conv_req(conv_req), .conv_pair(conv_pair), .conv_even_input(conv_even_input),
    .conv_odd_input(conv_odd_input), .irq(irq)
  );

  conv_engine_model u_eng (
    .pclk(pclk), .presetn(presetn), .conv_req(conv_req), .delay_cycles(eng_delay),
    .conv_done(conv_done)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****************************************************************
  // model, bus and check tasks
  // ****************************************************************
  // source index: 0 global, 1 special, 2..9 primary, 10 timer1,
  // 11..19 secondary, 20..27 current limit, 28 timer2
  function automatic int src_of(input int code);
    if (code >= 2 && code <= 12) return code - 2;
    if (code >= 14) return code - 3;
    return -1;
  endfunction

  function automatic logic [31:0] word(input int sl, input logic [7:0] b);
    return (sl % 2 == 1) ? {16'h0000, b, 8'h00} : {24'h000000, b};
  endfunction

  task automatic complete_run;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      complete_run;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // a missing fall of conv_req is a hang, a missing rise may be expected
  task automatic wait_req(input logic lvl);
    int n;
    hit = 1'b0;
    for (n = 0; n < 60 && !hit; n++) begin
      @(posedge pclk);
      hit = (conv_req === lvl);
    end
    if (!hit && !lvl) begin
      n_mismatch++;
      complete_run;
    end
  endtask

  // idx < 0 fires the slot's own software bit instead of a source line
  task automatic run_code(input int sl, input int code, input int idx);
    logic       en, m, ex;
    logic [7:0] a, b;
    en = 1'($urandom_range(0, 1));
    m  = 1'($urandom_range(0, 1));
    a  = ADDR_CTRL_0 + 8'(4 * (sl / 2));
    b  = {en, 2'b00, 5'(code)};
    ex = (idx < 0) ? (code == 1) : (idx == src_of(code));
    apb(1'b1, ADDR_IRQ_ENABLE, 32'(m) << sl);
    apb(1'b0, ADDR_IRQ_ENABLE, 32'h0);
    chk(rd, 32'(m) << sl);
    apb(1'b1, a, word(sl, b));
    if (idx < 0) begin
      apb(1'b1, a, word(sl, b | 8'h20));
    end else begin
      trg[idx] <= 1'b1;
      @(posedge pclk);
      trg <= '0;
    end
    apb(1'b0, a, 32'h0);
    chk(rd, word(sl, b | {1'b0, ex, idx < 0 && code != 1, 5'h00}));
    wait_req(1'b1);
    chk(32'(hit), 32'(ex));
    if (hit) begin
      chk({21'h0, conv_pair, conv_even_input, conv_odd_input},
          {21'h0, 3'(sl), 4'(2 * sl), 4'(2 * sl + 1)});
      wait_req(1'b0);
      repeat (3) @(posedge pclk);
      chk(32'(irq), 32'(en & m));
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk(rd, 32'(en) << sl);
      apb(1'b1, ADDR_IRQ_CLEAR, 32'h3f);
      apb(1'b0, a, 32'h0);
      chk(rd, word(sl, b));
    end
    apb(1'b1, a, 32'h0);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    pstrb       = 4'hf;
    trg         = '0;
    eng_delay   = 8'd20;
    n_mismatch  = 0;
    checks_done = 0;
    void'($urandom(32'hcbb2263a));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, plus the two unmapped words 0x0c and 0x1c
    for (s = 0; s < 8; s++) begin
      apb(1'b0, 8'(4 * s), 32'h0);
      chk(rd, 32'h0);
      chk(32'(er), 32'((s == 3 || s == 7) ? 1 : 0));
    end
    // every selector code: its own source, then a foreign one
    for (c = 0; c < 32; c++) begin
      s = $urandom_range(0, 5);
      run_code(s, c, src_of(c));
      j = $urandom_range(0, 28);
      if (j == src_of(c)) j = (j + 1) % 29;
      run_code(s, c, j);
    end
    // one timer pulse pends all six slots; grants must come in order
    for (s = 0; s < 3; s++) apb(1'b1, ADDR_CTRL_0 + 8'(4 * s), 32'h1f1f);
    trg[28] <= 1'b1;
    @(posedge pclk);
    trg <= '0;
    // model: one grant per pending slot, lowest number first
    for (s = 0; s < 6; s++) exp_q.push_back(s);
    for (s = 0; s < 6; s++) begin
      eng_delay <= 8'($urandom_range(1, 8));
      wait_req(1'b1);
      chk(32'({hit, conv_pair}), 32'({1'b1, 3'(exp_q.pop_front())}));
      wait_req(1'b0);
    end
    complete_run;
  end
endmodule
